// ===== hdl/abu_cfg.svh
// Constants of the address breakpoint unit: offsets, fields, resets.
// Assumes inclusion by bare name from the unit's design files.
`ifndef ABU_CFG_SVH
`define ABU_CFG_SVH
// Word indices on the register bus (byte address is four times these)
`define ABU_OFS_SCR 3'h0
`define ABU_OFS_ADH 3'h1
`define ABU_OFS_ADL 3'h2
`define ABU_OFS_AUX 3'h3
`define ABU_OFS_WES 3'h4
`define ABU_OFS_FCR 3'h5
`define ABU_OFS_IST 3'h6
`define ABU_OFS_IMK 3'h7
// Field positions
`define ABU_BIT_ENABLE 7
`define ABU_BIT_ACTIVE 6
`define ABU_BIT_WDOG 0
`define ABU_BIT_WAITX 1
`define ABU_BIT_CLRF 7
`define ABU_BIT_IRQ_BRK 0
`define ABU_BIT_IRQ_RTI 1
// Reset values
`define ABU_RST_BYTE 8'h00
`define ABU_RST_IRQ 2'h0
// Break vectors
`define ABU_VEC_NORMAL 16'hfffc
`define ABU_VEC_MONITOR 16'hfefc
`endif

// ===== hdl/abu_pkg.sv
// Types of the address breakpoint unit.
// Assumes nothing beyond a SystemVerilog compiler.
package abu_pkg;
	typedef enum logic [1:0] {
		ABU_IDLE,
		ABU_PEND,
		ABU_BREAK
	} abu_state_t;
endpackage

// ===== hdl/abu_break_unit.sv
// Address breakpoint unit: compare, break sequencing, register file.
// Assumes the CPU and integration logic run on clock and give
// one-cycle fetch, instruction-start and return strobes.
// Functional notes
// - With breaks enabled, a fetch address equal to the break address raises a breakpoint request.
// - A break loads the interrupt opcode and vectors to FFFC, or FEFC in monitor mode.
// - Writing one to the active bit breaks just before the next instruction.
// - A match on an opcode address breaks before that instruction runs.
// - A match on an operand address lets that instruction finish first.
// - The active bit is set by a match, cleared by writing zero, cleared by reset.
// - Bit 7 of the status/control register enables address-match breaks; zero or reset disables them.
// - The break address sits in high and low byte registers cleared by reset.
// - The timer counter is halted throughout a break.
// - The watchdog is disabled in a monitor-mode break when its disable bit is set.
// - Flags may be cleared during a break only when the clear-enable bit is one.
// - A status flag records that a break ended wait mode.
// - In wait and stop the unit stays enabled but no address match occurs.
// - A return from interrupt ends the break state.
// - Without a new break address, the same address never breaks again.
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "abu_cfg.svh"
module abu_break_unit
	import abu_pkg::*;
#(
	parameter logic [7:0] SWI_OPCODE = 8'h00
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_fetch,
	input wire logic cpu_opcode,
	input wire logic cpu_instr_start,
	input wire logic return_from_interrupt,
	input wire logic cpu_wait,
	input wire logic cpu_stop,
	input wire logic monitor_mode,
	output logic breakpoint_request,
	output logic [7:0] software_interrupt_opcode,
	output logic [15:0] vector_addr,
	output logic break_state,
	output logic timer_halt,
	output logic watchdog_disable,
	output logic flag_clear_allow,
	output logic irq
);

	abu_state_t state;
	abu_state_t next_state;
	logic break_enable_bit;
	logic next_break_enable_bit;
	logic break_active_bit;
	logic next_break_active_bit;
	logic [7:0] break_address_high;
	logic [7:0] next_break_address_high;
	logic [7:0] break_address_low;
	logic [7:0] next_break_address_low;
	logic break_watchdog_disable_bit;
	logic next_break_watchdog_disable_bit;
	logic wait_exit_by_break_flag;
	logic next_wait_exit_by_break_flag;
	logic break_flag_clear_enable;
	logic next_break_flag_clear_enable;
	logic armed;
	logic next_armed;
	logic [1:0] irq_status;
	logic [1:0] next_irq_status;
	logic [1:0] irq_mask;
	logic [1:0] next_irq_mask;
	logic bus_ack;
	logic next_bus_ack;
	logic [31:0] next_readdata;
	logic next_breakpoint_request;
	logic [15:0] next_vector_addr;
	logic bus_req;
	logic wr_en;
	logic [7:0] wbyte;
	logic [7:0] rd_byte;
	logic hit;
	logic sw_set;
	logic addr_write;
	logic fire;

	// Bus slave: every access answers one cycle after it is presented
	assign bus_req = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~bus_ack;
	assign wr_en = avs_write & bus_ack;
	assign wbyte = avs_writedata[7:0];

	always_comb
	begin
		rd_byte = 8'h00;
		case (avs_address)
			`ABU_OFS_SCR:
			begin
				rd_byte[`ABU_BIT_ENABLE] = break_enable_bit;
				rd_byte[`ABU_BIT_ACTIVE] = break_active_bit;
			end
			`ABU_OFS_ADH: rd_byte = break_address_high;
			`ABU_OFS_ADL: rd_byte = break_address_low;
			`ABU_OFS_AUX:
				rd_byte[`ABU_BIT_WDOG] = break_watchdog_disable_bit;
			`ABU_OFS_WES:
				rd_byte[`ABU_BIT_WAITX] = wait_exit_by_break_flag;
			`ABU_OFS_FCR:
				rd_byte[`ABU_BIT_CLRF] = break_flag_clear_enable;
			`ABU_OFS_IST: rd_byte[1:0] = irq_status;
			`ABU_OFS_IMK: rd_byte[1:0] = irq_mask;
			default: rd_byte = 8'h00;
		endcase
	end

	always_comb
	begin
		next_bus_ack = bus_req & ~bus_ack;
		next_readdata = avs_readdata;
		if (avs_read && !bus_ack)
			next_readdata = {24'h000000, rd_byte};
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			bus_ack <= 1'b0;
			avs_readdata <= 32'h00000000;
		end
		else
		begin
			bus_ack <= next_bus_ack;
			avs_readdata <= next_readdata;
		end
	end

	// Compare only fetch strobes, and none while wait or stop is high
	assign hit = break_enable_bit & cpu_fetch & armed &
		~cpu_wait & ~cpu_stop &
		(cpu_addr == {break_address_high, break_address_low}) &
		(state == ABU_IDLE);
	assign sw_set = wr_en & (avs_address == `ABU_OFS_SCR) &
		wbyte[`ABU_BIT_ACTIVE] & (state == ABU_IDLE);
	assign addr_write = wr_en & ((avs_address == `ABU_OFS_ADH) |
		(avs_address == `ABU_OFS_ADL));

	// Break sequencing
	always_comb
	begin
		next_state = state;
		fire = 1'b0;
		case (state)
			ABU_IDLE:
				if (hit && cpu_opcode)
				begin
					fire = 1'b1;
					next_state = ABU_BREAK;
				end
				else if (hit || sw_set)
					next_state = ABU_PEND;
			ABU_PEND:
				// A pending break also ends wait mode
				if (cpu_instr_start || cpu_wait)
				begin
					fire = 1'b1;
					next_state = ABU_BREAK;
				end
			ABU_BREAK:
				if (return_from_interrupt)
					next_state = ABU_IDLE;
			default: next_state = ABU_IDLE;
		endcase
		next_breakpoint_request = fire;
		next_vector_addr = vector_addr;
		if (fire)
			next_vector_addr = monitor_mode ? `ABU_VEC_MONITOR :
				`ABU_VEC_NORMAL;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state <= ABU_IDLE;
			breakpoint_request <= 1'b0;
			vector_addr <= `ABU_VEC_NORMAL;
		end
		else
		begin
			state <= next_state;
			breakpoint_request <= next_breakpoint_request;
			vector_addr <= next_vector_addr;
		end
	end

	// Register file; hardware sets win over software clears
	always_comb
	begin
		next_break_enable_bit = break_enable_bit;
		next_break_active_bit = break_active_bit;
		next_break_address_high = break_address_high;
		next_break_address_low = break_address_low;
		next_break_watchdog_disable_bit = break_watchdog_disable_bit;
		next_wait_exit_by_break_flag = wait_exit_by_break_flag;
		next_break_flag_clear_enable = break_flag_clear_enable;
		next_irq_mask = irq_mask;
		next_irq_status = irq_status;
		next_armed = armed;
		if (wr_en)
		begin
			case (avs_address)
				`ABU_OFS_SCR:
				begin
					next_break_enable_bit = wbyte[`ABU_BIT_ENABLE];
					next_break_active_bit = wbyte[`ABU_BIT_ACTIVE];
				end
				`ABU_OFS_ADH: next_break_address_high = wbyte;
				`ABU_OFS_ADL: next_break_address_low = wbyte;
				`ABU_OFS_AUX:
					next_break_watchdog_disable_bit = wbyte[`ABU_BIT_WDOG];
				`ABU_OFS_WES:
					if (!wbyte[`ABU_BIT_WAITX])
						next_wait_exit_by_break_flag = 1'b0;
				`ABU_OFS_FCR:
					next_break_flag_clear_enable = wbyte[`ABU_BIT_CLRF];
				`ABU_OFS_IST: next_irq_status = irq_status & ~wbyte[1:0];
				`ABU_OFS_IMK: next_irq_mask = wbyte[1:0];
				default: next_irq_mask = irq_mask;
			endcase
		end
		// Rearm only when the address is rewritten, so a return onto the
		// same opcode does not trap again
		if (addr_write)
			next_armed = 1'b1;
		if (hit)
		begin
			next_break_active_bit = 1'b1;
			next_armed = 1'b0;
		end
		if (fire && cpu_wait)
			next_wait_exit_by_break_flag = 1'b1;
		if (fire)
			next_irq_status[`ABU_BIT_IRQ_BRK] = 1'b1;
		if (state == ABU_BREAK && return_from_interrupt)
			next_irq_status[`ABU_BIT_IRQ_RTI] = 1'b1;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			break_enable_bit <= 1'b0;
			break_active_bit <= 1'b0;
			break_address_high <= `ABU_RST_BYTE;
			break_address_low <= `ABU_RST_BYTE;
			break_watchdog_disable_bit <= 1'b0;
			wait_exit_by_break_flag <= 1'b0;
			break_flag_clear_enable <= 1'b0;
			irq_status <= `ABU_RST_IRQ;
			irq_mask <= `ABU_RST_IRQ;
			armed <= 1'b1;
		end
		else
		begin
			break_enable_bit <= next_break_enable_bit;
			break_active_bit <= next_break_active_bit;
			break_address_high <= next_break_address_high;
			break_address_low <= next_break_address_low;
			break_watchdog_disable_bit <= next_break_watchdog_disable_bit;
			wait_exit_by_break_flag <= next_wait_exit_by_break_flag;
			break_flag_clear_enable <= next_break_flag_clear_enable;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			armed <= next_armed;
		end
	end

	// Effects of the break state on the rest of the device
	assign software_interrupt_opcode = SWI_OPCODE;
	assign break_state = (state == ABU_BREAK);
	assign timer_halt = break_state;
	assign watchdog_disable = break_state & monitor_mode &
		break_watchdog_disable_bit;
	assign flag_clear_allow = ~break_state | break_flag_clear_enable;
	assign irq = |(irq_status & irq_mask);

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence s_opc_hit;
		state == ABU_IDLE && hit && cpu_opcode;
	endsequence
	sequence s_in_break;
		breakpoint_request && state == ABU_BREAK;
	endsequence

	property p_opc_break;
		s_opc_hit |=> s_in_break;
	endproperty
	a_opc_break: assert property (p_opc_break)
		else $error("opcode match did not break at once");

	property p_vector;
		breakpoint_request |-> vector_addr == ($past(monitor_mode) ?
			`ABU_VEC_MONITOR : `ABU_VEC_NORMAL);
	endproperty
	a_vector: assert property (p_vector)
		else $error("wrong break vector");

	property p_operand;
		state == ABU_IDLE && hit && !cpu_opcode |=>
			!breakpoint_request && state == ABU_PEND;
	endproperty
	a_operand: assert property (p_operand)
		else $error("operand match broke too early");

	// An opcode match in the same cycle may take the break at once
	property p_sw_break;
		state == ABU_IDLE && sw_set |=>
			state != ABU_IDLE && break_active_bit;
	endproperty
	a_sw_break: assert property (p_sw_break)
		else $error("software break not registered");

	property p_pend_fire;
		state == ABU_PEND && cpu_instr_start |=> s_in_break;
	endproperty
	a_pend_fire: assert property (p_pend_fire)
		else $error("pending break not taken at instruction start");

	property p_active_set;
		hit |=> break_active_bit && !armed;
	endproperty
	a_active_set: assert property (p_active_set)
		else $error("match did not set active bit");

	property p_disabled;
		state == ABU_IDLE && !break_enable_bit && !sw_set |=>
			state == ABU_IDLE;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("break taken while disabled");

	property p_timer;
		s_in_break |-> timer_halt [*1] ##1 (timer_halt || !break_state);
	endproperty
	a_timer: assert property (p_timer)
		else $error("timer not halted in break");

	property p_rti;
		state == ABU_BREAK && return_from_interrupt |=>
			state == ABU_IDLE && !timer_halt && !watchdog_disable;
	endproperty
	a_rti: assert property (p_rti)
		else $error("return did not end break");

	property p_no_repeat;
		state == ABU_IDLE && !armed && !addr_write && !sw_set |=>
			state == ABU_IDLE;
	endproperty
	a_no_repeat: assert property (p_no_repeat)
		else $error("unarmed address broke again");

	property p_lowpower;
		state == ABU_IDLE && (cpu_wait || cpu_stop) && !sw_set &&
			!(wr_en && avs_address == `ABU_OFS_SCR) |=>
			state == ABU_IDLE && $stable(break_enable_bit);
	endproperty
	a_lowpower: assert property (p_lowpower)
		else $error("break triggered in low-power mode");

	property p_wait_flag;
		state == ABU_PEND && cpu_wait |=> wait_exit_by_break_flag;
	endproperty
	a_wait_flag: assert property (p_wait_flag)
		else $error("wait exit flag not set");

	property p_flag_guard;
		s_in_break ##0 !break_flag_clear_enable |-> !flag_clear_allow;
	endproperty
	a_flag_guard: assert property (p_flag_guard)
		else $error("flags clearable in break without enable");

endmodule
`default_nettype wire

// ===== testbench/abu_cpu_model.sv
// CPU and integration-logic model: fetch, instruction-start and return strobes.
// Assumes the bench calls its tasks; every strobe lasts one clock.
`timescale 1ns/1ps
`default_nettype none
module abu_cpu_model
(
	input wire logic clock,
	output logic [15:0] cpu_addr,
	output logic cpu_fetch,
	output logic cpu_opcode,
	output logic cpu_instr_start,
	output logic return_from_interrupt
);
	initial
	begin
		cpu_addr = 16'h0000;
		cpu_fetch = 1'b0;
		cpu_opcode = 1'b0;
		cpu_instr_start = 1'b0;
		return_from_interrupt = 1'b0;
	end
	// Address is inverted after the fetch so a stale match cannot pass
	task automatic fetch(input logic [15:0] a, input logic op);
		@(posedge clock);
		cpu_addr <= a;
		cpu_fetch <= 1'b1;
		cpu_opcode <= op;
		@(posedge clock);
		cpu_addr <= ~a;
		cpu_fetch <= 1'b0;
	endtask
	task automatic strobe(input logic ret);
		@(posedge clock);
		cpu_instr_start <= !ret;
		return_from_interrupt <= ret;
		@(posedge clock);
		cpu_instr_start <= 1'b0;
		return_from_interrupt <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== testbench/abu_break_unit_tb.sv
// Self-checking bench of the breakpoint unit against an integer model.
// Assumes the design files and the CPU model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module abu_break_unit_tb;
	import abu_pkg::*;
	localparam logic [7:0] SOFTWARE_INTERRUPT_OPCODE = 8'h5a; // Arbitrary opcode value
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [2:0] avs_address = 3'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic monitor_mode = 1'b0;
	logic cpu_wait = 1'b0;
	logic cpu_stop = 1'b0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, breakpoint_request, break_state, timer_halt;
	logic watchdog_disable, flag_clear_allow, irq, cpu_fetch, cpu_opcode;
	logic cpu_instr_start, return_from_interrupt;
	logic [15:0] cpu_addr, vector_addr;
	logic [7:0] software_interrupt_opcode;
	int mismatches = 0;
	int comparisons = 0;
	int cyc = 0;
	int m[8];
	abu_break_unit #(.SWI_OPCODE(SOFTWARE_INTERRUPT_OPCODE)) u_abu_break_unit (.clock, .rst,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .cpu_addr, .cpu_fetch, .cpu_opcode, .cpu_instr_start,
		.return_from_interrupt, .cpu_wait, .cpu_stop, .monitor_mode,
		.breakpoint_request, .software_interrupt_opcode, .vector_addr,
		.break_state, .timer_halt, .watchdog_disable, .flag_clear_allow, .irq);
	abu_cpu_model u_abu_cpu_model (.clock, .cpu_addr, .cpu_fetch, .cpu_opcode,
		.cpu_instr_start, .return_from_interrupt);
	initial
	begin
		forever #12.5 clock = ~clock;
	end
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Request stands until waitrequest is seen low at a rising edge;
	// read data is taken at that same edge, then the request drops
	task automatic bus(input logic w, input logic [2:0] a,
		input logic [7:0] d, output logic [31:0] q);
		@(posedge clock);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		do
			@(posedge clock);
		while (avs_waitrequest);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, m[a]);
	endtask
	// Writing one to the active bit sets it, so both bits follow the data
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
		case (a)
			3'h0: m[0] = d & 8'hc0;
			3'h1, 3'h2: m[a] = d;
			3'h3: m[3] = d & 8'h01;
			3'h4: m[4] = m[4] & (d | 8'hfd);
			3'h5: m[5] = d & 8'h80;
			3'h6: m[6] = m[6] & ~d;
			default: m[7] = d & 8'h03;
		endcase
	endtask
	task automatic none();
		#1;
		chk({breakpoint_request, break_state}, 2'b00);
	endtask
	task automatic brk(input logic [15:0] v, input logic w);
		#1;
		chk({breakpoint_request, break_state, timer_halt}, 3'b111);
		chk({software_interrupt_opcode, vector_addr}, {SOFTWARE_INTERRUPT_OPCODE, v});
		chk(watchdog_disable, monitor_mode & m[3][0]);
		chk(flag_clear_allow, m[5][7]);
		m[0] |= 8'h40;
		m[6] |= 1;
		if (w)
			m[4] |= 2;
		@(posedge clock);
		#1;
		chk({breakpoint_request, irq}, {1'b0, |(m[6] & m[7])});
		u_abu_cpu_model.strobe(1'b1);
		#1;
		chk({break_state, flag_clear_allow}, 2'b01);
		m[6] |= 2;
	endtask
	initial
	begin
		for (int i = 0; i < 8; i++)
			m[i] = 0;
		void'($urandom(95662));
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++)
			rd(3'(i));
		$display("test 1 reset values done");
		wr(3'h1, 8'h12);
		wr(3'h2, 8'h34);
		wr(3'h7, 8'h03);
		wr(3'h0, 8'h80);
		rd(3'h0);
		repeat (4)
		begin
			u_abu_cpu_model.fetch(16'h1234 ^ 16'(1 + $urandom % 65535), 1'b1);
			none();
		end
		u_abu_cpu_model.fetch(16'h1234, 1'b1);
		brk(16'hfffc, 1'b0);
		rd(3'h0);
		rd(3'h6);
		chk(irq, 1'b1);
		wr(3'h6, 8'h03);
		chk(irq, 1'b0);
		$display("test 2 opcode break done");
		wr(3'h0, 8'h80);
		u_abu_cpu_model.fetch(16'h1234, 1'b1);
		none();
		wr(3'h2, 8'h56);
		wr(3'h7, 8'h01);
		u_abu_cpu_model.fetch(16'h1256, 1'b0);
		none();
		u_abu_cpu_model.strobe(1'b0);
		brk(16'hfffc, 1'b0);
		$display("test 3 repeat and operand done");
		@(posedge clock) monitor_mode <= 1'b1;
		wr(3'h7, 8'h02);
		wr(3'h3, 8'h01);
		wr(3'h5, 8'h80);
		wr(3'h0, 8'hc0);
		none();
		u_abu_cpu_model.strobe(1'b0);
		brk(16'hfefc, 1'b0);
		rd(3'h3);
		rd(3'h5);
		wr(3'h0, 8'h80);
		rd(3'h0);
		$display("test 4 software break done");
		wr(3'h2, 8'h78);
		@(posedge clock) cpu_wait <= 1'b1;
		u_abu_cpu_model.fetch(16'h1278, 1'b1);
		none();
		wr(3'h0, 8'hc0);
		@(posedge clock);
		brk(16'hfefc, 1'b1);
		@(posedge clock) cpu_wait <= 1'b0;
		rd(3'h4);
		wr(3'h4, 8'h00);
		rd(3'h4);
		@(posedge clock) cpu_stop <= 1'b1;
		wr(3'h0, 8'h80);
		u_abu_cpu_model.fetch(16'h1278, 1'b1);
		none();
		@(posedge clock) cpu_stop <= 1'b0;
		wr(3'h0, 8'h00);
		u_abu_cpu_model.fetch(16'h1278, 1'b1);
		none();
		rd(3'h0);
		$display("test 5 low power and disable done");
		// Reset in mid-run must clear registers that hold set values
		@(posedge clock) rst <= 1'b1;
		@(posedge clock) rst <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			m[i] = 0;
			rd(3'(i));
		end
		$display("test 6 mid-run reset done");
		end_of_test();
	end
endmodule
`default_nettype wire
